/* File: ittd_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module ittd_alu import ittd_pkg::*; (
    input wire logic [3:0] fn_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cin_i,
    output ittd_alu_out_t out_o
);
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic cy;

    assign cy = (fn_i == FN_ADC || fn_i == FN_SBC) ? cin_i : 1'b0;
    assign sum9 = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cy};
    assign diff9 = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy};

    always_comb begin
        out_o = '0;
        out_o.carry = cin_i;
        case (fn_i)
            FN_PASS_M: out_o.result = b_i;
            FN_PASS_A: out_o.result = a_i;
            FN_ADD, FN_ADC: begin
                out_o.result = sum9[7:0];
                out_o.carry = sum9[8];
                out_o.carry_we = 1'b1;
                out_o.zero_we = 1'b1;
            end
            FN_SUB, FN_SBC: begin
                out_o.result = diff9[7:0];
                out_o.carry = diff9[8];
                out_o.carry_we = 1'b1;
                out_o.zero_we = 1'b1;
            end
            FN_AND, FN_OR, FN_XOR, FN_CPL: begin
                out_o.result = (fn_i == FN_AND) ? (a_i & b_i) : (fn_i == FN_OR) ? (a_i | b_i) :
                    (fn_i == FN_XOR) ? (a_i ^ b_i) : ~b_i;
                out_o.zero_we = 1'b1;
            end
            FN_INC, FN_DEC: begin
                out_o.result = (fn_i == FN_INC) ? b_i + 8'h01 : b_i - 8'h01;
                out_o.zero_we = 1'b1;
            end
            FN_RR: out_o.result = {b_i[0], b_i[7:1]};
            FN_RL: out_o.result = {b_i[6:0], b_i[7]};
            FN_RRC: begin
                out_o.result = {cin_i, b_i[7:1]};
                out_o.carry = b_i[0];
                out_o.carry_we = 1'b1;
            end
            FN_RLC: begin
                out_o.result = {b_i[6:0], cin_i};
                out_o.carry = b_i[7];
                out_o.carry_we = 1'b1;
            end
            default: out_o.result = b_i;
        endcase
        out_o.zero = (out_o.result == 8'h00);
    end
endmodule // ittd_alu
`default_nettype wire

/* File: ittd_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ittd_core import ittd_pkg::*; #(
    parameter int DEPTH_STACK = STACK_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [IW-1:0] prog_data_i,
    input wire logic wdt_timeout_i,
    input wire logic wake_i,
    output logic [PC_W-1:0] prog_addr_o,
    output logic [DATA_W-1:0] acc_o,
    output logic [DATA_W-1:0] table_high_o,
    output logic carry_o,
    output logic zero_o,
    output logic global_interrupt_enable_o,
    output logic watchdog_timeout_flag_o,
    output logic power_down_flag_o,
    output logic power_down_o,
    output logic wdt_clear_o,
    output logic instr_start_o
);
    localparam int SP_W = $clog2(DEPTH_STACK);

    ittd_state_t state;
    ittd_pre_t last_pre;
    logic [1:0] phase;
    logic [IW-1:0] ir;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack [DEPTH_STACK];
    logic [SP_W-1:0] sp;
    logic [DATA_W-1:0] ram_rdata;
    logic wake_meta;
    logic wake_sync;

    // decode
    logic [1:0] cls;
    logic is_alu;
    logic is_bit;
    logic is_misc;
    logic is_br;
    logic is_call;
    logic dest_mem;
    logic use_imm;
    logic [3:0] fn;
    logic [2:0] kind;
    logic [2:0] bitn;
    logic [5:0] mop;
    logic [DATA_W-1:0] oper;
    logic [PC_W-1:0] target;

    assign cls = ir[CLS_HI:CLS_LO];
    assign is_alu = (cls == CLS_ALU);
    assign is_bit = (cls == CLS_BIT);
    assign is_misc = (cls == CLS_MISC);
    assign is_br = (cls == CLS_BR);
    assign is_call = ir[CALL_BIT];
    assign dest_mem = ir[DEST_BIT];
    assign use_imm = ir[IMM_BIT];
    assign fn = ir[FN_HI:FN_LO];
    assign kind = ir[KIND_HI:KIND_LO];
    assign bitn = ir[BITN_HI:BITN_LO];
    assign mop = ir[MOP_HI:MOP_LO];
    assign oper = ir[OPER_HI:0];
    assign target = ir[TGT_HI:0];

    logic op_ret;
    logic op_interrupt_exit;
    logic op_halt;
    logic op_wclr;
    logic op_pre1;
    logic op_pre2;
    logic op_table;

    assign op_ret = is_misc && (mop == MOP_SUB_EXIT);
    assign op_interrupt_exit = is_misc && (mop == MOP_INT_EXIT);
    assign op_halt = is_misc && (mop == MOP_HALT);
    assign op_wclr = is_misc && (mop == MOP_WDT_CLR);
    assign op_pre1 = is_misc && (mop == MOP_WDT_PRE1);
    assign op_pre2 = is_misc && (mop == MOP_WDT_PRE2);
    assign op_table = is_misc && (mop == MOP_TABLE);

    // operand fetch; the low program counter byte reads back at its address
    logic [DATA_W-1:0] mem_val;
    logic [DATA_W-1:0] operand_b;
    logic [DATA_W-1:0] bit_mask;
    logic bit_val;
    logic [3:0] alu_fn;
    ittd_alu_out_t alu_out;

    assign mem_val = (oper == PCL_ADDR) ? pc[DATA_W-1:0] : ram_rdata;
    assign operand_b = (is_alu && use_imm) ? oper : mem_val;
    assign bit_mask = ONE_HOT_BIT0 << bitn;
    assign bit_val = |(mem_val & bit_mask);
    assign alu_fn = !is_bit ? fn : (kind == BK_SKINC) ? FN_INC : (kind == BK_SKDEC) ? FN_DEC : FN_PASS_M;

    ittd_alu u_alu (
        .fn_i(alu_fn),
        .a_i(acc_o),
        .b_i(operand_b),
        .cin_i(carry_o),
        .out_o(alu_out)
    );

    // execution strobes
    logic exec;
    logic table_exec;
    logic bit_write;
    logic mem_write;
    logic acc_write;
    logic skip_taken;
    logic pcl_write;
    logic pre_pair;
    logic [DATA_W-1:0] write_val;

    assign exec = (state == ST_RUN) && (phase == PH_LAST);
    assign table_exec = (state == ST_TABLE) && (phase == PH_LAST);
    assign bit_write = is_bit && (kind == BK_CLR || kind == BK_SET || kind == BK_SKINC || kind == BK_SKDEC);
    assign mem_write = (is_alu && dest_mem) || bit_write;
    assign acc_write = (is_alu && !dest_mem) || (is_bit && kind == BK_SKZA);
    assign write_val = !is_bit ? alu_out.result : (kind == BK_CLR) ? (mem_val & ~bit_mask) :
        (kind == BK_SET) ? (mem_val | bit_mask) : alu_out.result;
    assign pcl_write = mem_write && (oper == PCL_ADDR);

    logic skip_cond;
    always_comb begin
        case (kind)
            BK_SKZ: skip_cond = !bit_val;
            BK_SKNZ: skip_cond = bit_val;
            BK_SKZM, BK_SKZA: skip_cond = (mem_val == 8'h00);
            BK_SKINC, BK_SKDEC: skip_cond = alu_out.zero;
            default: skip_cond = 1'b0;
        endcase
    end
    assign skip_taken = is_bit && skip_cond;

    assign pre_pair = (op_pre1 && last_pre == PRE_TWO) || (op_pre2 && last_pre == PRE_ONE);

    // next program counter
    logic [PC_W-1:0] pc_plus1;
    logic [PC_W-1:0] next_pc;
    logic [SP_W-1:0] sp_top;
    logic two_cycle;

    assign pc_plus1 = pc + PC_STEP;
    assign sp_top = sp - SP_W'(1);
    assign next_pc = is_br ? target :
        (op_ret || op_interrupt_exit) ? stack[sp_top] :
        pcl_write ? {pc[PC_W-1:DATA_W], write_val} :
        skip_taken ? pc + PC_SKIP : pc_plus1;
    assign two_cycle = is_br || op_ret || op_interrupt_exit || pcl_write || skip_taken;

    // table read second cycle: page of the current counter, low byte from the accumulator
    logic [PC_W-1:0] table_addr;
    assign table_addr = {pc[PC_W-1:DATA_W], acc_o};

    // data memory port
    logic ram_we;
    logic [DATA_W-1:0] ram_wdata;
    assign ram_we = (exec && mem_write && !pcl_write) || (table_exec && oper != PCL_ADDR);
    assign ram_wdata = table_exec ? prog_data_i[DATA_W-1:0] : write_val;

    ittd_ram #(
        .WIDTH(DATA_W),
        .DEPTH(RAM_DEPTH)
    ) u_ram (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .we_i(ram_we),
        .waddr_i(oper),
        .wdata_i(ram_wdata),
        .raddr_i(oper),
        .rdata_o(ram_rdata)
    );

    // wake pin synchroniser
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_i;
            wake_sync <= wake_meta;
        end
    end

    // four-phase instruction cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase <= 2'h0;
            instr_start_o <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            instr_start_o <= (phase == PH_LAST);
        end
    end

    // sequencing state
    ittd_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (exec) begin
                    if (op_halt) begin
                        next_state = ST_SLEEP;
                    end else if (op_table) begin
                        next_state = ST_TABLE;
                    end else if (two_cycle) begin
                        next_state = ST_BUBBLE;
                    end
                end
            end
            ST_BUBBLE: if (phase == PH_LAST) next_state = ST_RUN;
            ST_TABLE: if (phase == PH_LAST) next_state = ST_RUN;
            ST_SLEEP: if (phase == PH_LAST && wake_sync) next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_RUN;
            power_down_o <= 1'b0;
        end else begin
            state <= next_state;
            power_down_o <= (next_state == ST_SLEEP);
        end
    end

    // instruction latch; a dropped word never reaches execute
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ir <= NOP_WORD;
        end else if (state == ST_RUN && phase == PH_FETCH) begin
            ir <= prog_data_i;
        end
    end

    // program counter and fetch address
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc <= PC_RESET;
            prog_addr_o <= PC_RESET;
        end else if (exec) begin
            pc <= op_table ? pc_plus1 : next_pc;
            prog_addr_o <= op_table ? table_addr : next_pc;
        end else if (table_exec) begin
            prog_addr_o <= pc;
        end
    end

    // return stack
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sp <= '0;
        end else if (exec && is_br && is_call) begin
            sp <= sp + SP_W'(1);
        end else if (exec && (op_ret || op_interrupt_exit)) begin
            sp <= sp_top;
        end
    end

    always_ff @(posedge clk_i) begin
        if (exec && is_br && is_call) begin
            stack[sp] <= pc_plus1;
        end
    end

    // accumulator, flags, table high byte
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_o <= 8'h00;
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            table_high_o <= 8'h00;
        end else begin
            if (exec && acc_write) begin
                acc_o <= alu_out.result;
            end
            if (exec && is_alu && alu_out.carry_we) begin
                carry_o <= alu_out.carry;
            end
            if (exec && is_alu && alu_out.zero_we) begin
                zero_o <= alu_out.zero;
            end
            if (table_exec) begin
                table_high_o <= prog_data_i[IW-1:HIGH_LO];
            end
        end
    end

    // interrupt enable
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            global_interrupt_enable_o <= 1'b0;
        end else if (exec && op_interrupt_exit) begin
            global_interrupt_enable_o <= 1'b1;
        end
    end

    // watchdog flags; a timeout in the clearing cycle wins
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_timeout_flag_o <= 1'b0;
            power_down_flag_o <= 1'b0;
            wdt_clear_o <= 1'b0;
            last_pre <= PRE_NONE;
        end else begin
            wdt_clear_o <= exec && (op_wclr || pre_pair);
            if (wdt_timeout_i) begin
                watchdog_timeout_flag_o <= 1'b1;
            end else if (exec && (op_wclr || pre_pair || op_halt)) begin
                watchdog_timeout_flag_o <= 1'b0;
            end
            if (exec && op_halt) begin
                power_down_flag_o <= 1'b1;
            end else if (exec && (op_wclr || pre_pair)) begin
                power_down_flag_o <= 1'b0;
            end
            if (exec) begin
                last_pre <= (op_pre1 && !pre_pair) ? PRE_ONE : (op_pre2 && !pre_pair) ? PRE_TWO : PRE_NONE;
            end
        end
    end
endmodule // ittd_core
`default_nettype wire

/* File: ittd_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ittd_core_sva import ittd_pkg::*; (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [PC_W-1:0] prog_addr_o,
    input wire logic [DATA_W-1:0] acc_o,
    input wire logic [DATA_W-1:0] table_high_o,
    input wire logic carry_o,
    input wire logic zero_o,
    input wire logic global_interrupt_enable_o,
    input wire logic watchdog_timeout_flag_o,
    input wire logic power_down_flag_o,
    input wire logic power_down_o,
    input wire logic wdt_clear_o,
    input wire logic instr_start_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_start_period: assert property (
        instr_start_o |=> (!instr_start_o) [*3] ##1 (instr_start_o || power_down_o))
        else $error("instruction start spacing wrong");
    a_addr_stands: assert property (
        instr_start_o |=> $stable(prog_addr_o) [*3])
        else $error("fetch address moved inside a cycle");
    a_pc_moves: assert property (
        !$stable(prog_addr_o) |-> instr_start_o)
        else $error("fetch address moved off the cycle edge");
    a_state_moves: assert property (
        !$stable({acc_o, carry_o, zero_o}) |-> instr_start_o)
        else $error("accumulator or flags moved off the cycle edge");
    a_table_load: assert property (
        !$stable(table_high_o) |-> instr_start_o)
        else $error("table high byte moved off the cycle edge");
    a_gie_keep: assert property (
        !$fell(global_interrupt_enable_o))
        else $error("interrupt enable cleared");
    a_sleep_still: assert property (
        power_down_o && $past(power_down_o) |-> $stable(prog_addr_o) && $stable(acc_o))
        else $error("state moved while asleep");
    a_halt_flags: assert property (
        $rose(power_down_o) |-> power_down_flag_o && !watchdog_timeout_flag_o)
        else $error("halt flags wrong");
    a_clear_pair: assert property (
        wdt_clear_o |-> ##[0:1] (!watchdog_timeout_flag_o && !power_down_flag_o))
        else $error("watchdog clear left flags set");
    a_timeout_keep: assert property (
        $fell(watchdog_timeout_flag_o) |-> wdt_clear_o || $past(wdt_clear_o) || power_down_o)
        else $error("timeout flag cleared without cause");
    c_int_exit: cover property ($rose(global_interrupt_enable_o));
    c_sleep: cover property ($rose(power_down_o));
    c_clear: cover property (wdt_clear_o);
endmodule // ittd_core_sva
bind ittd_core ittd_core_sva u_sva (
    .clk_i(clk_i), .reset_i(reset_i), .prog_addr_o(prog_addr_o), .acc_o(acc_o),
    .table_high_o(table_high_o), .carry_o(carry_o), .zero_o(zero_o),
    .global_interrupt_enable_o(global_interrupt_enable_o),
    .watchdog_timeout_flag_o(watchdog_timeout_flag_o), .power_down_flag_o(power_down_flag_o),
    .power_down_o(power_down_o), .wdt_clear_o(wdt_clear_o), .instr_start_o(instr_start_o)
);
`default_nettype wire

/* File: ittd_pkg.sv */
package ittd_pkg;
    localparam int PC_W = 12;
    localparam int DATA_W = 8;
    localparam int IW = 16;
    localparam int STACK_DEPTH = 8;
    localparam int RAM_DEPTH = 256;
    localparam int PHASES = 4;
    localparam logic [1:0] PH_FETCH = 2'h1;
    localparam logic [1:0] PH_LAST = 2'h3;
    // instruction word fields
    localparam int CLS_HI = 15;
    localparam int CLS_LO = 14;
    localparam int DEST_BIT = 13;
    localparam int IMM_BIT = 12;
    localparam int FN_HI = 11;
    localparam int FN_LO = 8;
    localparam int KIND_HI = 13;
    localparam int KIND_LO = 11;
    localparam int BITN_HI = 10;
    localparam int BITN_LO = 8;
    localparam int MOP_HI = 13;
    localparam int MOP_LO = 8;
    localparam int CALL_BIT = 13;
    localparam int OPER_HI = 7;
    localparam int TGT_HI = 11;
    localparam int HIGH_LO = 8;
    localparam logic [1:0] CLS_ALU = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_MISC = 2'h2;
    localparam logic [1:0] CLS_BR = 2'h3;
    // alu functions
    localparam logic [3:0] FN_PASS_M = 4'h0;
    localparam logic [3:0] FN_ADD = 4'h1;
    localparam logic [3:0] FN_ADC = 4'h2;
    localparam logic [3:0] FN_SUB = 4'h3;
    localparam logic [3:0] FN_SBC = 4'h4;
    localparam logic [3:0] FN_AND = 4'h5;
    localparam logic [3:0] FN_OR = 4'h6;
    localparam logic [3:0] FN_XOR = 4'h7;
    localparam logic [3:0] FN_CPL = 4'h8;
    localparam logic [3:0] FN_INC = 4'h9;
    localparam logic [3:0] FN_DEC = 4'ha;
    localparam logic [3:0] FN_RR = 4'hb;
    localparam logic [3:0] FN_RL = 4'hc;
    localparam logic [3:0] FN_RRC = 4'hd;
    localparam logic [3:0] FN_RLC = 4'he;
    localparam logic [3:0] FN_PASS_A = 4'hf;
    // bit and skip kinds
    localparam logic [2:0] BK_CLR = 3'h0;
    localparam logic [2:0] BK_SET = 3'h1;
    localparam logic [2:0] BK_SKZ = 3'h2;
    localparam logic [2:0] BK_SKNZ = 3'h3;
    localparam logic [2:0] BK_SKZM = 3'h4;
    localparam logic [2:0] BK_SKINC = 3'h5;
    localparam logic [2:0] BK_SKDEC = 3'h6;
    localparam logic [2:0] BK_SKZA = 3'h7;
    // misc operations
    localparam logic [5:0] MOP_NOP = 6'h00;
    localparam logic [5:0] MOP_SUB_EXIT = 6'h01;
    localparam logic [5:0] MOP_INT_EXIT = 6'h02;
    localparam logic [5:0] MOP_HALT = 6'h03;
    localparam logic [5:0] MOP_WDT_CLR = 6'h04;
    localparam logic [5:0] MOP_WDT_PRE1 = 6'h05;
    localparam logic [5:0] MOP_WDT_PRE2 = 6'h06;
    localparam logic [5:0] MOP_TABLE = 6'h07;
    localparam logic [15:0] NOP_WORD = 16'h8000;
    localparam logic [7:0] PCL_ADDR = 8'h06;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [11:0] PC_STEP = 12'h001;
    localparam logic [11:0] PC_SKIP = 12'h002;
    localparam logic [7:0] ONE_HOT_BIT0 = 8'h01;

    typedef enum logic [1:0] {ST_RUN, ST_BUBBLE, ST_TABLE, ST_SLEEP} ittd_state_t;
    typedef enum logic [1:0] {PRE_NONE, PRE_ONE, PRE_TWO} ittd_pre_t;

    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic zero;
        logic carry_we;
        logic zero_we;
    } ittd_alu_out_t;
endpackage

/* File: ittd_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module ittd_prog_mem import ittd_pkg::*; (
    input wire logic [PC_W-1:0] addr_i,
    output logic [IW-1:0] data_o
);
    logic [IW-1:0] words [0:(1<<PC_W)-1];
    // unprogrammed words read as no-operation
    initial begin
        for (int i = 0; i < (1<<PC_W); i++) words[i] = NOP_WORD;
    end
    assign data_o = words[addr_i];
endmodule // ittd_prog_mem
`default_nettype wire

/* File: ittd_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module ittd_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule // ittd_ram
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ittd_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wdt_timeout_i = 1'b0;
    logic wake_i = 1'b0;
    logic [IW-1:0] prog_data_i;
    logic [PC_W-1:0] prog_addr_o;
    logic [7:0] acc_o, table_high_o;
    logic carry_o, zero_o, gie_o, wto_o, pdf_o, power_down_o, wdt_clear_o, instr_start_o;
    int failures = 0;
    int checks = 0;
    logic [11:0] e_pc[$];
    logic [7:0] e_acc[$];
    logic e_c[$], e_z[$];
    int e_n[$];
    logic [7:0] ea, r0, r1, r2, r3;
    logic [8:0] s;
    logic ec, ez;
    always #5 clk_i = ~clk_i;
    ittd_prog_mem pm (.addr_i(prog_addr_o), .data_o(prog_data_i));
    ittd_core dut (
        .clk_i(clk_i), .reset_i(reset_i), .prog_data_i(prog_data_i), .wdt_timeout_i(wdt_timeout_i),
        .wake_i(wake_i), .prog_addr_o(prog_addr_o), .acc_o(acc_o), .table_high_o(table_high_o),
        .carry_o(carry_o), .zero_o(zero_o), .global_interrupt_enable_o(gie_o),
        .watchdog_timeout_flag_o(wto_o), .power_down_flag_o(pdf_o), .power_down_o(power_down_o),
        .wdt_clear_o(wdt_clear_o), .instr_start_o(instr_start_o)
    );
    task automatic close_out();
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({11'h000, got}, {11'h000, exp});
    endtask
    task automatic wait_start();
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_i);
            #1;
            if (instr_start_o === 1'b1) return;
        end
        failures++;
        close_out();
    endtask
    // program word plus state expected once it has run
    task automatic put(input logic [11:0] a, input logic [15:0] w, input int n, input logic [11:0] nxt);
        pm.words[a] = w;
        e_n.push_back(n);
        e_pc.push_back(nxt);
        e_acc.push_back(ea);
        e_c.push_back(ec);
        e_z.push_back(ez);
    endtask
    function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
        return {1'b0, a} - {1'b0, b};
    endfunction
    initial begin
        void'($urandom(79705));
        r0 = 8'($urandom);
        r1 = 8'($urandom);
        r2 = 8'($urandom);
        r3 = 8'($urandom);
        repeat (2) @(posedge clk_i);
        ea = r0; ec = 1'b0; ez = 1'b0;
        put(12'h000, {8'h10, r0}, 1, 12'h001);
        put(12'h001, 16'h2f10, 1, 12'h002);
        s = ea + r1; ea = s[7:0]; ec = s[8]; ez = (ea == 8'h00);
        put(12'h002, {8'h11, r1}, 1, 12'h003);
        s = sub9(ea, r2); ea = s[7:0]; ec = s[8]; ez = (ea == 8'h00);
        put(12'h003, {8'h13, r2}, 1, 12'h004);
        ea = ea & r0; ez = (ea == 8'h00);
        put(12'h004, 16'h0510, 1, 12'h005);
        pm.words[12'h005] = {8'h17, ea};
        ea = 8'h00; ez = 1'b1;
        put(12'h005, {8'h17, e_acc[4]}, 1, 12'h006);
        ea = r0 + 8'h01; ez = (ea == 8'h00);
        put(12'h006, 16'h0910, 1, 12'h007);
        ea = {ec, r0[7:1]}; ec = r0[0];
        put(12'h007, 16'h0d10, 1, 12'h008);
        put(12'h008, 16'h4b10, 1, 12'h009);
        ea = r0 | 8'h08;
        put(12'h009, 16'h0010, 1, 12'h00a);
        put(12'h00a, 16'h5310, 1, 12'h00b);
        put(12'h00b, 16'h5b10, 2, 12'h00d);
        pm.words[12'h00c] = 16'h1101;
        put(12'h00d, 16'he060, 2, 12'h060);
        ea = 8'h01;
        put(12'h060, 16'h1001, 1, 12'h061);
        put(12'h061, 16'h2f12, 1, 12'h062);
        pm.words[12'h063] = 16'h1055;
        pm.words[12'h065] = 16'h1055;
        put(12'h062, 16'h7012, 2, 12'h064);
        ea = 8'h00;
        put(12'h064, 16'h7812, 2, 12'h066);
        put(12'h066, 16'h4310, 1, 12'h067);
        put(12'h067, 16'h6812, 1, 12'h068);
        ea = r0 & 8'hf7;
        put(12'h068, 16'h0010, 1, 12'h069);
        s = ea + r2 + ec; ea = s[7:0]; ec = s[8]; ez = (ea == 8'h00);
        put(12'h069, {8'h12, r2}, 1, 12'h06a);
        s = sub9(ea, r1) - ec; ea = s[7:0]; ec = s[8]; ez = (ea == 8'h00);
        put(12'h06a, {8'h14, r1}, 1, 12'h06b);
        ea = ea | r3; ez = (ea == 8'h00);
        put(12'h06b, {8'h16, r3}, 1, 12'h06c);
        ea = {r1[6:0], ec}; ec = r1[7];
        put(12'h06c, {8'h1e, r1}, 1, 12'h06d);
        put(12'h06d, 16'h8100, 2, 12'h00e);
        put(12'h00e, 16'hc020, 2, 12'h020);
        put(12'h020, 16'he030, 2, 12'h030);
        ea = r3;
        put(12'h030, {8'h10, r3}, 1, 12'h031);
        put(12'h031, 16'h8200, 2, 12'h021);
        ea = 8'h40;
        put(12'h021, 16'h1040, 1, 12'h022);
        put(12'h022, 16'h2f06, 2, 12'h040);
        put(12'h040, 16'h8711, 2, 12'h041);
        ea = 8'h11;
        put(12'h041, 16'h0011, 1, 12'h042);
        put(12'h042, 16'h8500, 1, 12'h043);
        put(12'h043, 16'h8600, 1, 12'h044);
        put(12'h044, 16'h8300, 1, 12'h045);
        pm.words[12'h045] = 16'hc045;
        repeat (3) @(posedge clk_i);
        #1 reset_i = 1'b0;
        @(posedge clk_i);
        #1 wdt_timeout_i = 1'b1;
        @(posedge clk_i);
        #1 wdt_timeout_i = 1'b0;
        chk_val(prog_addr_o, 12'h000);
        foreach (e_n[i]) begin
            for (int j = 0; j < e_n[i]; j++) wait_start();
            chk_val(prog_addr_o, e_pc[i]);
            chk_val({4'h0, acc_o}, {4'h0, e_acc[i]});
            chk_bit(carry_o, e_c[i]);
            chk_bit(zero_o, e_z[i]);
            if (e_pc[i] == 12'h031) chk_bit(gie_o, 1'b0);
            if (e_pc[i] == 12'h00e) chk_bit(gie_o, 1'b0);
            if (e_pc[i] == 12'h021) chk_bit(gie_o, 1'b1);
            if (e_pc[i] == 12'h041) chk_val({4'h0, table_high_o}, 12'h087);
            if (e_pc[i] == 12'h043) chk_bit(wto_o, 1'b1);
            if (e_pc[i] == 12'h044) chk_bit(wto_o, 1'b0);
            if (e_pc[i] == 12'h043) chk_bit(wdt_clear_o, 1'b0);
            if (e_pc[i] == 12'h044) chk_bit(wdt_clear_o, 1'b1);
        end
        chk_bit(power_down_o, 1'b1);
        chk_bit(pdf_o, 1'b1);
        repeat (8) @(posedge clk_i);
        chk_bit(power_down_o, 1'b1);
        #1 wake_i = 1'b1;
        for (int k = 0; k < 40 && power_down_o !== 1'b0; k++) begin
            @(posedge clk_i);
            #1;
        end
        #1 wake_i = 1'b0;
        chk_bit(power_down_o, 1'b0);
        wait_start();
        wait_start();
        chk_val(prog_addr_o, 12'h045);
        close_out();
    end
endmodule // testbench
`default_nettype wire
